/* File: hdl/lict_top.sv */
// local interrupt controller with timer for one processor core
// assumes all inputs are driven by logic on i_core_clk;
// the core pulses i_eoi_wr at the end of each handler
//
// Overview of operation
// - 32-bit down counter clocked by core clock over the programmed divisor.
// - one-shot: writing initial count loads current count and starts counting.
// - one-shot: at zero raise timer interrupt and hold zero until rewritten.
// - periodic: at zero raise interrupt, reload from initial count, repeat.
// - writing initial count mid-countdown restarts from the new value.
// - timer interrupt uses the table vector; its mask suppresses delivery.
// - command shorthand 2'b01 delivers the commanded interrupt to this core.
// - interrupts for other processors are neither sent nor received.
// - destination mode 0 physical, 1 logical; physical id in bits 59:56.
// - logical mode accepts by matching address against logical/format regs.
// - priority class is vector over 16, 1 lowest, 15 highest.
// - dispatch only classes above task priority; 0 admits, 15 blocks all.
// - processor priority is max of top in-service class and task priority.
// - 256-bit request and in-service vectors; accepting sets request bit.
// - when core ready, move top request to in-service and dispatch it.
// - end-of-interrupt write clears top in-service bit; requests still queue.
// - same vector may sit in both; at most two per class, rest rejected.
// - higher class than in-service dispatches at once if core enabled.
// - on accept, trigger bit cleared for edge, set for level sources.
// - end-of-interrupt on a level vector broadcasts to external controllers.
// - vectors 0 to 15 flag an illegal-vector error.
// - a software enable flag gates arrivals and dispatch; timer and command latch keep running.
`timescale 1ns/1ps
`default_nettype none
`include "lict_defines.svh"

module lict_top
   import lict_pkg::*;
#(
   parameter int NUM_VEC = `LICT_NUM_VEC,
   parameter logic [3:0] CTRL_ID = `LICT_CTRL_ID
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // global enable and priority
   input wire logic i_sw_enable,
   input wire logic [3:0] i_task_priority,
   output logic [3:0] o_proc_priority,
   // timer configuration
   input wire logic [`LICT_DIV_SEL_W-1:0] i_div_sel,
   input wire logic [`LICT_VEC_W-1:0] i_lvt_vector,
   input wire logic i_lvt_mask,
   input wire logic i_lvt_periodic,
   input wire logic i_init_wr,
   input wire logic [`LICT_TMR_W-1:0] i_init_count,
   output logic [`LICT_TMR_W-1:0] o_cur_count,
   output logic o_timer_running,
   // command register write
   input wire logic i_cmd_wr,
   input wire logic [`LICT_VEC_W-1:0] i_cmd_vector,
   input wire logic i_cmd_level,
   input wire logic i_cmd_dest_mode,
   input wire logic [1:0] i_cmd_shorthand,
   input wire logic [7:0] i_cmd_dest,
   output logic o_cmd_pending,
   // logical destination and format
   input wire logic [7:0] i_logical_dest,
   input wire logic [3:0] i_dest_format,
   // external fixed interrupt source
   input wire logic i_ext_valid,
   input wire logic [`LICT_VEC_W-1:0] i_ext_vector,
   input wire logic i_ext_level,
   output logic o_ext_ready,
   // error status
   input wire logic i_err_clear,
   output logic o_err_illegal_vec,
   // core side
   input wire logic i_core_ready,
   output logic o_dispatch_valid,
   output logic [`LICT_VEC_W-1:0] o_dispatch_vector,
   input wire logic i_eoi_wr,
   output logic o_eoi_broadcast,
   output logic [`LICT_VEC_W-1:0] o_eoi_vector
);

   // ------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------
   if (NUM_VEC != `LICT_NUM_VEC) begin : g_chk
      $error("lict_top: NUM_VEC must be 256");
   end

   // ------------------------------------------------------------
   // helper functions
   // ------------------------------------------------------------

   // priority class of a vector
   function automatic logic [3:0] class_of(
      input logic [`LICT_VEC_W-1:0] v
   );
      class_of = v[`LICT_VEC_W-1:`LICT_CLASS_LSB];
   endfunction

   // number of queued entries in one class, both vectors counted
   function automatic logic [5:0] class_load(
      input logic [`LICT_NUM_VEC-1:0] rq,
      input logic [`LICT_NUM_VEC-1:0] sv,
      input logic [3:0] cls
   );
      logic [5:0] n;
      n = '0;
      for (int k = 0; k < `LICT_CLASS_SIZE; k++) begin
         n = n + 6'(rq[{cls, 4'(k)}]) + 6'(sv[{cls, 4'(k)}]);
      end
      class_load = n;
   endfunction

   // command destination decode
   function automatic logic cmd_for_me(
      input logic [1:0] sh,
      input logic dm,
      input logic [7:0] dest,
      input logic [7:0] logical_dest_register,
      input logic [3:0] dest_format_register
   );
      logic hit;
      hit = 1'b0;
      if (sh == `LICT_SH_SELF) begin
         hit = 1'b1;
      end else if (sh == `LICT_SH_NONE) begin
         if (dm == `LICT_DM_PHYS) begin
            hit = (dest[3:0] == CTRL_ID);
         end else if (dest_format_register == `LICT_DFR_FLAT) begin
            hit = ((dest & logical_dest_register) != 8'h00);
         end else if (dest_format_register == `LICT_DFR_CLUSTER) begin
            hit = (dest[7:4] == logical_dest_register[7:4]) &&
                  ((dest[3:0] & logical_dest_register[3:0]) != 4'h0);
         end
      end
      // other shorthands address other processors
      cmd_for_me = hit;
   endfunction

   // ------------------------------------------------------------
   // state and submodules
   // ------------------------------------------------------------
   lict_ctrl_st_t st;
   lict_ctrl_st_t next_st;

   logic timer_fire;
   logic req_valid;
   logic [`LICT_VEC_W-1:0] req_top;
   logic svc_valid;
   logic [`LICT_VEC_W-1:0] svc_top;

   lict_timer u_timer (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_div_sel(i_div_sel),
      .i_periodic(i_lvt_periodic),
      .i_init_wr(i_init_wr),
      .i_init_count(i_init_count),
      .o_cur_count(o_cur_count),
      .o_running(o_timer_running),
      .o_fire(timer_fire)
   );

   lict_prio_enc #(
      .N(`LICT_NUM_VEC)
   ) u_req_enc (
      .i_bits(st.req),
      .o_valid(req_valid),
      .o_index(req_top)
   );

   lict_prio_enc #(
      .N(`LICT_NUM_VEC)
   ) u_svc_enc (
      .i_bits(st.insvc),
      .o_valid(svc_valid),
      .o_index(svc_top)
   );

   // ------------------------------------------------------------
   // processor priority and dispatch gate
   // ------------------------------------------------------------
   logic [3:0] svc_class;
   logic [3:0] processor_priority_register;
   logic do_dispatch;
   logic do_eoi;

   assign svc_class = svc_valid ? class_of(svc_top) : 4'h0;
   assign processor_priority_register = (svc_class > i_task_priority) ?
                svc_class : i_task_priority;
   // a strictly higher class preempts the one in service
   assign do_dispatch = i_sw_enable && i_core_ready && req_valid &&
                        (class_of(req_top) > processor_priority_register);
   assign do_eoi = i_eoi_wr && svc_valid;

   // ------------------------------------------------------------
   // arrival arbitration: timer, then command, then external
   // ------------------------------------------------------------
   logic arr_valid;
   logic [`LICT_VEC_W-1:0] arr_vec;
   logic arr_level;
   logic arr_timer;
   logic arr_cmd;

   assign arr_timer = i_sw_enable && st.timer_pend;
   assign arr_cmd = i_sw_enable && !st.timer_pend && st.cmd_pend;
   assign o_ext_ready = i_sw_enable && !st.timer_pend &&
                        !st.cmd_pend;
   assign arr_valid = arr_timer || arr_cmd ||
                      (o_ext_ready && i_ext_valid);
   assign arr_vec = arr_timer ? i_lvt_vector :
                    arr_cmd ? st.cmd_vec : i_ext_vector;
   // timer entries are edge sources
   assign arr_level = arr_timer ? 1'b0 :
                      arr_cmd ? st.cmd_level : i_ext_level;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.disp_valid = 1'b0;
      next_st.eoi_bc = 1'b0;
      next_st.processor_priority_register = processor_priority_register;

      // retire the top in-service entry
      if (do_eoi) begin
         next_st.insvc[svc_top] = 1'b0;
         if (st.trig[svc_top]) begin
            next_st.eoi_bc = 1'b1;
            next_st.eoi_vec = svc_top;
         end
      end

      // move top request into service and hand it to the core
      if (do_dispatch) begin
         next_st.req[req_top] = 1'b0;
         next_st.insvc[req_top] = 1'b1;
         next_st.disp_valid = 1'b1;
         next_st.disp_vec = req_top;
      end

      // consume the arbitrated arrival
      if (arr_timer) begin
         next_st.timer_pend = 1'b0;
      end
      if (arr_cmd) begin
         next_st.cmd_pend = 1'b0;
      end
      if (i_err_clear) begin
         next_st.illegal_vec = 1'b0;
      end
      if (arr_valid) begin
         if (arr_vec < `LICT_FIRST_LEGAL) begin
            next_st.illegal_vec = 1'b1;
         end else if (class_load(st.req, st.insvc, class_of(arr_vec))
                      < `LICT_MAX_PER_CLASS) begin
            // sets after the dispatch clear so a repeat is kept
            next_st.req[arr_vec] = 1'b1;
            next_st.trig[arr_vec] = arr_level;
         end
         // a third entry in one class is dropped
      end

      // new events set after the consumes above
      if (timer_fire && !i_lvt_mask) begin
         next_st.timer_pend = 1'b1;
      end
      if (i_cmd_wr && cmd_for_me(i_cmd_shorthand, i_cmd_dest_mode,
                                 i_cmd_dest, i_logical_dest,
                                 i_dest_format)) begin
         next_st.cmd_pend = 1'b1;
         next_st.cmd_vec = i_cmd_vector;
         next_st.cmd_level = i_cmd_level;
         if (i_cmd_vector < `LICT_FIRST_LEGAL) begin
            next_st.illegal_vec = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_proc_priority = st.processor_priority_register;
   assign o_cmd_pending = st.cmd_pend; // delivery status
   assign o_err_illegal_vec = st.illegal_vec;
   assign o_dispatch_valid = st.disp_valid;
   assign o_dispatch_vector = st.disp_vec;
   assign o_eoi_broadcast = st.eoi_bc;
   assign o_eoi_vector = st.eoi_vec;

endmodule // lict_top

`default_nettype wire

/* File: common/lict_defines.svh */
// constants for the local interrupt controller with timer
// assumes inclusion by bare name from the package and design files
`ifndef LICT_DEFINES_SVH
`define LICT_DEFINES_SVH

// ---------------------------------------------------------------
// vector space and priority classes
// ---------------------------------------------------------------
`define LICT_NUM_VEC 256
`define LICT_VEC_W 8
`define LICT_CLASS_LSB 4
`define LICT_CLASS_SIZE 16
`define LICT_FIRST_LEGAL 8'h10
`define LICT_MAX_PER_CLASS 6'h02

// ---------------------------------------------------------------
// command register fields
// ---------------------------------------------------------------
`define LICT_SH_NONE 2'h0
`define LICT_SH_SELF 2'h1
`define LICT_DM_PHYS 1'b0
`define LICT_DM_LOGIC 1'b1
`define LICT_DFR_FLAT 4'hf
`define LICT_DFR_CLUSTER 4'h0

// ---------------------------------------------------------------
// timer
// ---------------------------------------------------------------
`define LICT_TMR_W 32
`define LICT_DIV_SEL_W 3
`define LICT_PRESC_W 7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LICT_CTRL_ID 4'h0
`define LICT_COUNT_RST 32'h0000_0000

`endif

/* File: common/lict_pkg.sv */
// types shared by the local interrupt controller files
// assumes lict_defines.svh is on the include path
`include "lict_defines.svh"

package lict_pkg;

   // ------------------------------------------------------------
   // timer state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [`LICT_PRESC_W-1:0] presc;
      logic [`LICT_TMR_W-1:0] count;
      logic running;
      logic fire;
   } lict_timer_st_t;

   // ------------------------------------------------------------
   // controller state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [`LICT_NUM_VEC-1:0] req;
      logic [`LICT_NUM_VEC-1:0] insvc;
      logic [`LICT_NUM_VEC-1:0] trig;
      logic timer_pend;
      logic cmd_pend;
      logic [`LICT_VEC_W-1:0] cmd_vec;
      logic cmd_level;
      logic illegal_vec;
      logic disp_valid;
      logic [`LICT_VEC_W-1:0] disp_vec;
      logic eoi_bc;
      logic [`LICT_VEC_W-1:0] eoi_vec;
      logic [3:0] processor_priority_register;
   } lict_ctrl_st_t;

endpackage

/* File: hdl/lict_prio_enc.sv */
// highest-set-bit finder over a vector of request bits
// assumes a purely combinational use inside one clock domain
`timescale 1ns/1ps
`default_nettype none

module lict_prio_enc #(
   parameter int N = 256
) (
   input wire logic [N-1:0] i_bits,
   output logic o_valid,
   output logic [$clog2(N)-1:0] o_index
);

   // ------------------------------------------------------------
   // parameter check
   // ------------------------------------------------------------
   if (N < 2) begin : g_chk
      $error("lict_prio_enc: N must be at least 2");
   end

   // ------------------------------------------------------------
   // scan upward so the highest set bit wins
   // ------------------------------------------------------------
   always_comb begin
      o_valid = 1'b0;
      o_index = '0;
      for (int k = 0; k < N; k++) begin
         if (i_bits[k]) begin
            o_valid = 1'b1;
            o_index = k[$clog2(N)-1:0];
         end
      end
   end

endmodule // lict_prio_enc

`default_nettype wire

/* File: hdl/lict_timer.sv */
// down-counting timer with prescaler, one-shot and periodic modes
// assumes control inputs come from logic on i_core_clk
`timescale 1ns/1ps
`default_nettype none
`include "lict_defines.svh"

module lict_timer
   import lict_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [`LICT_DIV_SEL_W-1:0] i_div_sel,
   input wire logic i_periodic,
   input wire logic i_init_wr,
   input wire logic [`LICT_TMR_W-1:0] i_init_count,
   output logic [`LICT_TMR_W-1:0] o_cur_count,
   output logic o_running,
   output logic o_fire
);

   lict_timer_st_t st;
   lict_timer_st_t next_st;
   logic [`LICT_PRESC_W-1:0] presc_max;
   logic tick;

   // ------------------------------------------------------------
   // time base: clock divided by 2**i_div_sel
   // ------------------------------------------------------------
   assign presc_max = `LICT_PRESC_W'((1 << i_div_sel) - 1);
   assign tick = (st.presc >= presc_max);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.fire = 1'b0;
      next_st.presc = tick ? '0 : st.presc + 1'b1;
      if (i_init_wr) begin
         // a write restarts the countdown; zero stops it
         next_st.count = i_init_count;
         next_st.running = (i_init_count != '0);
         next_st.presc = '0;
      end else if (st.running && tick) begin
         if (st.count == `LICT_TMR_W'(1)) begin
            next_st.fire = 1'b1;
            if (i_periodic) begin
               next_st.count = i_init_count;
            end else begin
               next_st.count = '0; // hold at zero
               next_st.running = 1'b0;
            end
         end else begin
            next_st.count = st.count - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_cur_count = st.count;
   assign o_running = st.running;
   assign o_fire = st.fire;

endmodule // lict_timer

`default_nettype wire

/* File: tb/lict_core_model.sv */
// processor core model: takes dispatched vectors and ends each handler
// assumes the controller's outputs are registered on i_core_clk
`timescale 1ns/1ps
`default_nettype none

module lict_core_model (
   input wire logic i_core_clk,
   input wire logic i_irq_en,
   input wire logic i_auto_eoi,
   input wire logic i_dispatch_valid,
   output logic o_core_ready,
   output logic o_eoi_wr
);
   int depth = 0;
   int wait_cnt = 0;
   initial o_eoi_wr = 1'b0;
   // the core takes interrupts only while it has them enabled
   assign o_core_ready = i_irq_en;
   // every handler ends with one end-of-interrupt write
   always @(negedge i_core_clk) begin
      o_eoi_wr <= 1'b0;
      depth = depth + (i_dispatch_valid === 1'b1 ? 1 : 0);
      if (i_auto_eoi && depth > 0) begin
         wait_cnt = wait_cnt + 1;
         if (wait_cnt >= 3) begin
            o_eoi_wr <= 1'b1;
            depth = depth - 1;
            wait_cnt = 0;
         end
      end
   end
endmodule // lict_core_model

`default_nettype wire

/* File: tb/lict_top_assertions.sv */
// checker for the controller top, watching its ports only
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module lict_top_assertions (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_sw_enable,
   input wire logic [3:0] i_task_priority,
   input wire logic [3:0] o_proc_priority,
   input wire logic i_init_wr,
   input wire logic [31:0] i_init_count,
   input wire logic [31:0] o_cur_count,
   input wire logic o_timer_running,
   input wire logic i_core_ready,
   input wire logic o_dispatch_valid,
   input wire logic [7:0] o_dispatch_vector,
   input wire logic i_eoi_wr,
   input wire logic o_eoi_broadcast
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   a_off_no_disp: assert property (!i_sw_enable |=> !o_dispatch_valid)
      else $error("dispatch while controller disabled");
   a_busy_no_disp: assert property (!i_core_ready |=> !o_dispatch_valid)
      else $error("dispatch while core not ready");
   a_disp_above_tpr: assert property (o_dispatch_valid |->
      o_dispatch_vector[7:4] > $past(i_task_priority))
      else $error("dispatched class not above task priority");
   a_disp_legal_vec: assert property (o_dispatch_valid |->
      o_dispatch_vector >= 8'h10)
      else $error("reserved vector dispatched");
   a_ppr_over_tpr: assert property ($past(i_rst_n) |->
      o_proc_priority >= $past(i_task_priority))
      else $error("processor priority below task priority");
   a_init_loads: assert property (i_init_wr |->
      ##1 o_cur_count == $past(i_init_count))
      else $error("initial count not loaded");
   a_zero_stops: assert property (i_init_wr && i_init_count == 32'h0
      |=> !o_timer_running)
      else $error("zero initial count left timer running");
   a_count_step: assert property (!$past(i_init_wr) &&
      $past(o_cur_count) != 32'h0 && $changed(o_cur_count) |->
      o_cur_count == $past(o_cur_count) - 32'h1 ||
      o_cur_count == $past(i_init_count))
      else $error("count moved other than down by one or reload");
   a_zero_holds: assert property (o_cur_count == 32'h0 && !i_init_wr
      |=> o_cur_count == 32'h0)
      else $error("expired count did not hold at zero");
   a_eoi_cause: assert property (o_eoi_broadcast |-> $past(i_eoi_wr))
      else $error("broadcast without end-of-interrupt write");
endmodule // lict_top_assertions

bind lict_top lict_top_assertions i_lict_top_assertions (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_sw_enable(i_sw_enable),
   .i_task_priority(i_task_priority), .o_proc_priority(o_proc_priority),
   .i_init_wr(i_init_wr), .i_init_count(i_init_count),
   .o_cur_count(o_cur_count), .o_timer_running(o_timer_running),
   .i_core_ready(i_core_ready), .o_dispatch_valid(o_dispatch_valid),
   .o_dispatch_vector(o_dispatch_vector), .i_eoi_wr(i_eoi_wr),
   .o_eoi_broadcast(o_eoi_broadcast)
);

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the controller top with a core model
// assumes inputs change at the falling edge of a 50 MHz clock
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic clk = 1'b0, rst_n = 1'b0, en = 1'b1, lmask = 1'b0, lper = 1'b0;
   logic iwr = 1'b0, cwr = 1'b0, clvl = 1'b0, cmode = 1'b0, xv = 1'b0;
   logic xlvl = 1'b0, eclr = 1'b0, irq_en = 1'b1, auto_eoi = 1'b1;
   logic [3:0] task_priority_register = 4'h0, dest_format_register = 4'hf, processor_priority_register;
   logic [2:0] div = 3'h0;
   logic [1:0] csh = 2'h0;
   logic [7:0] lvec = 8'h3a, cvec = 8'h0, cdest = 8'h0, logical_dest_register = 8'h0;
   logic [7:0] xvec = 8'h0, dvec, bvec, lastv, lastb;
   logic [31:0] icnt = 32'h0, cur;
   logic run, cpend, xrdy, ill, crdy, dv, end_of_interrupt, bc;
   int failures = 0, tests_run = 0, nd, nb;
   // design and core model
   lict_top i_lict_top (.i_core_clk(clk), .i_rst_n(rst_n),
      .i_sw_enable(en), .i_task_priority(task_priority_register), .o_proc_priority(processor_priority_register),
      .i_div_sel(div), .i_lvt_vector(lvec), .i_lvt_mask(lmask),
      .i_lvt_periodic(lper), .i_init_wr(iwr), .i_init_count(icnt),
      .o_cur_count(cur), .o_timer_running(run), .i_cmd_wr(cwr),
      .i_cmd_vector(cvec), .i_cmd_level(clvl), .i_cmd_dest_mode(cmode),
      .i_cmd_shorthand(csh), .i_cmd_dest(cdest), .o_cmd_pending(cpend),
      .i_logical_dest(logical_dest_register), .i_dest_format(dest_format_register), .i_ext_valid(xv),
      .i_ext_vector(xvec), .i_ext_level(xlvl), .o_ext_ready(xrdy),
      .i_err_clear(eclr), .o_err_illegal_vec(ill), .i_core_ready(crdy),
      .o_dispatch_valid(dv), .o_dispatch_vector(dvec), .i_eoi_wr(end_of_interrupt),
      .o_eoi_broadcast(bc), .o_eoi_vector(bvec));
   lict_core_model i_lict_core_model (.i_core_clk(clk), .i_irq_en(irq_en),
      .i_auto_eoi(auto_eoi), .i_dispatch_valid(dv), .o_core_ready(crdy),
      .o_eoi_wr(end_of_interrupt));
   // 20 ns clock
   always #10 clk = ~clk;

   task automatic chk(input string nm, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // count dispatch and broadcast pulses over n cycles
   task automatic watch(input int n);
      nd = 0;
      nb = 0;
      repeat (n) begin
         tick(1);
         if (dv === 1'b1) begin
            nd++;
            lastv = dvec;
         end
         if (bc === 1'b1) begin
            nb++;
            lastb = bvec;
         end
      end
   endtask
   task automatic cmd(input logic [7:0] v, input logic l, m,
         input logic [1:0] s, input logic [7:0] d);
      cvec = v;
      clvl = l;
      cmode = m;
      csh = s;
      cdest = d;
      cwr = 1'b1;
      tick(1);
      cwr = 1'b0;
   endtask
   task automatic init(input logic [31:0] c);
      icnt = c;
      iwr = 1'b1;
      tick(1);
      iwr = 1'b0;
   endtask
   task automatic ext(input logic [7:0] v);
      int n = 0;
      xvec = v;
      xv = 1'b1;
      while (xrdy !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      chk("ext_ready", 32'h1, {31'h0, xrdy});
      tick(1);
      xv = 1'b0;
      tick(1);
   endtask

   task automatic t_oneshot();
      int n = 0;
      div = 3'h2;
      init(32'h3);
      chk("load", 32'h3, cur);
      while (cur !== 32'h2 && n < 20) begin
         tick(1);
         n++;
      end
      n = 0;
      while (cur === 32'h2 && n < 20) begin
         tick(1);
         n++;
      end
      chk("tick_span", 32'h4, 32'(n));
      watch(20);
      chk("timer_vec", {24'h0, 8'h3a}, {24'h0, lastv});
      chk("oneshot_fires", 32'h1, 32'(nd));
      chk("hold_zero", 32'h0, cur);
      lmask = 1'b1;
      init(32'h2);
      watch(20);
      chk("masked", 32'h0, 32'(nd));
      lmask = 1'b0;
   endtask
   task automatic t_periodic();
      div = 3'h0;
      lper = 1'b1;
      init(32'h8);
      watch(30);
      chk("periodic_fires", 32'h1, 32'(nd >= 2));
      chk("periodic_runs", 32'h1, {31'h0, run});
      init(32'h20);
      chk("restart", 32'h20, cur);
      tick(1);
      init(32'h0);
      watch(20);
      chk("zero_stop", 32'h0, {cur[30:0], run});
      chk("zero_no_irq", 32'h0, 32'(nd));
      lper = 1'b0;
   endtask
   // rows: shorthand, mode, destination, logical id, accepted
   task automatic t_cmd();
      logic [19:0] tab [7] = '{{2'h1, 1'b0, 8'h07, 8'h00, 1'b1},
         {2'h2, 1'b0, 8'h00, 8'h00, 1'b0}, {2'h3, 1'b0, 8'h00, 8'h00, 1'b0},
         {2'h0, 1'b0, 8'h10, 8'h00, 1'b1}, {2'h0, 1'b0, 8'h01, 8'h00, 1'b0},
         {2'h0, 1'b1, 8'h24, 8'h04, 1'b1}, {2'h0, 1'b1, 8'h24, 8'h40, 1'b0}};
      for (int i = 0; i < 7; i++) begin
         logical_dest_register = tab[i][8:1];
         cmd(8'h60 + 8'(i), 1'b0, tab[i][17], tab[i][19:18], tab[i][16:9]);
         chk("cmd_accept", {31'h0, tab[i][0]}, {31'h0, cpend});
         watch(10);
         chk("cmd_dispatch", {31'h0, tab[i][0]}, 32'(nd));
      end
      // cluster format: high nibble names the cluster, low nibble members
      dest_format_register = 4'h0;
      logical_dest_register = 8'h21;
      cmd(8'h68, 1'b0, 1'b1, 2'h0, 8'h23);
      chk("cluster_hit", 32'h1, {31'h0, cpend});
      watch(10);
      chk("cluster_disp", 32'h1, 32'(nd));
      cmd(8'h69, 1'b0, 1'b1, 2'h0, 8'h31);
      chk("cluster_miss", 32'h0, {31'h0, cpend});
      dest_format_register = 4'hf;
      tick(1);
      cmd(8'h05, 1'b0, 1'b0, 2'h1, 8'h00);
      watch(8);
      chk("illegal_flag", 32'h1, {31'h0, ill});
      chk("illegal_no_irq", 32'h0, 32'(nd));
      eclr = 1'b1;
      tick(1);
      eclr = 1'b0;
      tick(1);
      chk("illegal_clear", 32'h0, {31'h0, ill});
   endtask
   task automatic t_prio();
      auto_eoi = 1'b0;
      task_priority_register = 4'hf;
      cmd(8'h80, 1'b0, 1'b0, 2'h1, 8'h00);
      watch(8);
      chk("tpr_blocks", 32'h0, 32'(nd));
      task_priority_register = 4'h0;
      watch(6);
      chk("tpr_admits", {24'h0, 8'h80}, {24'h0, lastv});
      chk("ppr_isr", 32'h8, {28'h0, processor_priority_register});
      cmd(8'h75, 1'b0, 1'b0, 2'h1, 8'h00);
      watch(6);
      chk("ppr_gates", 32'h0, 32'(nd));
      cmd(8'hc1, 1'b1, 1'b0, 2'h1, 8'h00);
      watch(6);
      chk("preempt", {24'h0, 8'hc1}, {24'h0, lastv});
      chk("ppr_top", 32'hc, {28'h0, processor_priority_register});
      auto_eoi = 1'b1;
      watch(40);
      chk("after_eoi", {24'h0, 8'h75}, {24'h0, lastv});
      chk("broadcasts", 32'h1, 32'(nb));
      chk("bcast_vec", {24'h0, 8'hc1}, {24'h0, lastb});
   endtask
   task automatic t_limit();
      irq_en = 1'b0;
      ext(8'h90);
      ext(8'h91);
      ext(8'h92);
      tick(2);
      irq_en = 1'b1;
      watch(40);
      chk("class_limit", 32'h2, 32'(nd));
      en = 1'b0;
      tick(1);
      chk("off_ready", 32'h0, {31'h0, xrdy});
      cmd(8'h50, 1'b0, 1'b0, 2'h1, 8'h00);
      watch(10);
      chk("off_no_irq", 32'h0, 32'(nd));
      en = 1'b1;
      watch(20);
      chk("resume_count", 32'h1, 32'(nd));
      chk("resume_vec", {24'h0, 8'h50}, {24'h0, lastv});
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // main sequence after a 16-cycle reset
   initial begin
      tick(16);
      rst_n = 1'b1;
      tick(2);
      t_oneshot();
      t_periodic();
      t_cmd();
      t_prio();
      t_limit();
      report_and_stop();
   end
   // watchdog well beyond the expected run length
   initial begin
      #200us;
      failures++;
      report_and_stop();
   end
endmodule // testbench

`default_nettype wire
